// >>> shared/cosod_pkg.sv
// Constants of the standard object directory block.
package cosod_pkg;

  // ****************************************
  // Object indices
  // ****************************************
  localparam logic [15:0] IDX_DEVICE_TYPE   = 16'h1000;
  localparam logic [15:0] IDX_ERROR_SUMMARY = 16'h1001;
  localparam logic [15:0] IDX_ERROR_HISTORY = 16'h1003;
  localparam logic [15:0] IDX_DEVICE_NAME   = 16'h1008;
  localparam logic [15:0] IDX_HW_VERSION    = 16'h1009;
  localparam logic [15:0] IDX_SW_VERSION    = 16'h100A;
  localparam logic [15:0] IDX_IDENTITY      = 16'h1018;
  localparam logic [15:0] IDX_TX_MAP_FIRST  = 16'h1A00;
  localparam logic [15:0] IDX_TX_MAP_LAST   = 16'h1A18;
  localparam logic [15:0] IDX_SYNC_TYPES    = 16'h1C00;
  localparam logic [15:0] IDX_TX_ASSIGN     = 16'h1C13;

  // ****************************************
  // Contents and reset values
  // ****************************************
  localparam logic [7:0]  ERR_SUMMARY_RESET = 8'h00;
  localparam int          ERR_GENERAL_BIT   = 0;
  localparam int          ERR_MANUF_BIT     = 7;
  localparam logic [7:0]  IDENTITY_ENTRIES  = 8'h04;
  localparam logic [7:0]  TX_MAP_ENTRIES    = 8'h2B;
  localparam logic [15:0] TX_MAP1_INDEX     = 16'h6065;
  localparam logic [7:0]  TX_MAP1_SUB       = 8'h01;
  localparam logic [7:0]  TX_MAP1_LEN       = 8'h20;
  localparam logic [7:0]  SYNC_CHANNELS     = 8'h04;
  localparam logic [7:0]  SYNC_TYPE_BASE    = 8'h01;
  localparam logic [7:0]  MAX_OVERSAMPLE    = 8'h19;
  localparam int          STR_LEN           = 8;

  // ****************************************
  // Access codes
  // ****************************************
  localparam logic [1:0]  RSP_OK            = 2'h0;
  localparam logic [1:0]  RSP_NO_OBJECT     = 2'h1;
  localparam logic [1:0]  RSP_READ_ONLY     = 2'h2;
  localparam logic [1:0]  RSP_BAD_STATE     = 2'h3;

endpackage

// >>> hdl/cosod_directory.sv
// Standard communication object directory reached by SDO-style read and write requests.
`timescale 1ns/1ps
module cosod_directory #(
  parameter logic [31:0]        DEVICE_TYPE   = 32'h0000_0001,
  parameter logic [31:0]        MAKER_ID      = 32'h0000_0A5A,
  parameter logic [31:0]        PRODUCT_CODE  = 32'h0000_1234,
  parameter logic [31:0]        REVISION_CODE = 32'h0000_0001,
  parameter logic [31:0]        SERIAL_CODE   = 32'h0000_0042,
  parameter logic [8*8-1:0]     NAME_STR      = 64'h5345_4E53_4F52_0000,
  parameter logic [8*8-1:0]     HW_STR        = 64'h5620_312E_3030_3000,
  parameter logic [8*8-1:0]     SW_STR        = 64'h5620_312E_3030_3000
) (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             req_valid_i,
  input  wire logic             req_write_i,
  input  wire logic [15:0]      req_index_i,
  input  wire logic [7:0]       req_sub_i,
  input  wire logic [31:0]      req_wdata_i,
  input  wire logic             preop_i,
  input  wire logic [4:0]       oversample_i,
  input  wire logic             err_event_i,
  input  wire logic [31:0]      err_code_i,
  input  wire logic             err_active_i,
  input  wire logic             err_manuf_i,
  output logic                  rsp_valid_o,
  output logic                  rsp_abort_o,
  output logic [1:0]            rsp_code_o,
  output logic [31:0]           rsp_rdata_o,
  output logic [7:0]            error_summary_o
);

  // ****************************************
  // Error state
  // ****************************************
  logic [7:0]  err_count_q;
  logic [31:0] err_last_q;
  logic [7:0]  err_summary_q;
  logic        hist_clear;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      err_count_q <= 8'h00;
      err_last_q  <= 32'h0000_0000;
    end else if (err_event_i) begin
      // A new error wins over a clear in the same cycle.
      err_last_q <= err_code_i;
      if (hist_clear) begin
        err_count_q <= 8'h01;
      end else if (err_count_q != 8'hFF) begin
        err_count_q <= err_count_q + 8'h01;
      end
    end else if (hist_clear) begin
      err_count_q <= 8'h00;
      err_last_q  <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      err_summary_q <= cosod_pkg::ERR_SUMMARY_RESET;
    end else begin
      err_summary_q <= 8'h00;
      err_summary_q[cosod_pkg::ERR_GENERAL_BIT] <= err_active_i | err_manuf_i;
      err_summary_q[cosod_pkg::ERR_MANUF_BIT]   <= err_manuf_i;
    end
  end

  assign error_summary_o = err_summary_q;

  // ****************************************
  // Request decode
  // ****************************************
  logic [31:0] rd_data;
  logic [1:0]  rd_code;
  logic        wr_allowed;
  logic [7:0]  assign_count;

  assign assign_count = {3'h0, oversample_i} + 8'h01;

  function automatic logic [7:0] str_byte(input logic [8*8-1:0] s, input logic [7:0] sub);
    logic [2:0] pos;
    pos = 3'(sub);
    return s[(7 - pos)*8 +: 8];
  endfunction

  always_comb begin
    rd_data    = 32'h0000_0000;
    rd_code    = cosod_pkg::RSP_OK;
    wr_allowed = 1'b0;
    // Fixed objects are selected by their full 16-bit index; mapping records by the index range 1A00h to 1A18h.
    case (req_index_i)
      cosod_pkg::IDX_DEVICE_TYPE: begin
        if (req_sub_i == 8'h00) rd_data = DEVICE_TYPE;
        else rd_code = cosod_pkg::RSP_NO_OBJECT;
      end
      cosod_pkg::IDX_ERROR_SUMMARY: begin
        if (req_sub_i == 8'h00) rd_data = {24'h0, err_summary_q};
        else rd_code = cosod_pkg::RSP_NO_OBJECT;
      end
      cosod_pkg::IDX_ERROR_HISTORY: begin
        if (req_sub_i == 8'h00) begin
          rd_data    = {24'h0, err_count_q};
          wr_allowed = 1'b1;
        end else if (req_sub_i == 8'h01) begin
          rd_data = err_last_q;
        end else begin
          rd_code = cosod_pkg::RSP_NO_OBJECT;
        end
      end
      cosod_pkg::IDX_DEVICE_NAME: begin
        if (req_sub_i < 8'(cosod_pkg::STR_LEN)) rd_data = {24'h0, str_byte(NAME_STR, req_sub_i)};
        else rd_code = cosod_pkg::RSP_NO_OBJECT;
      end
      cosod_pkg::IDX_HW_VERSION: begin
        if (req_sub_i < 8'(cosod_pkg::STR_LEN)) rd_data = {24'h0, str_byte(HW_STR, req_sub_i)};
        else rd_code = cosod_pkg::RSP_NO_OBJECT;
      end
      cosod_pkg::IDX_SW_VERSION: begin
        if (req_sub_i < 8'(cosod_pkg::STR_LEN)) rd_data = {24'h0, str_byte(SW_STR, req_sub_i)};
        else rd_code = cosod_pkg::RSP_NO_OBJECT;
      end
      cosod_pkg::IDX_IDENTITY: begin
        case (req_sub_i)
          8'h00: rd_data = {24'h0, cosod_pkg::IDENTITY_ENTRIES};
          8'h01: rd_data = MAKER_ID;
          8'h02: rd_data = PRODUCT_CODE;
          8'h03: rd_data = REVISION_CODE;
          8'h04: rd_data = SERIAL_CODE;
          default: rd_code = cosod_pkg::RSP_NO_OBJECT;
        endcase
      end
      cosod_pkg::IDX_SYNC_TYPES: begin
        if (req_sub_i == 8'h00) begin
          rd_data = {24'h0, cosod_pkg::SYNC_CHANNELS};
        end else if (req_sub_i <= cosod_pkg::SYNC_CHANNELS) begin
          rd_data = {24'h0, req_sub_i - 8'h01 + cosod_pkg::SYNC_TYPE_BASE};
        end else begin
          rd_code = cosod_pkg::RSP_NO_OBJECT;
        end
      end
      cosod_pkg::IDX_TX_ASSIGN: begin
        if (req_sub_i == 8'h00) begin
          rd_data = {24'h0, assign_count};
        end else if (req_sub_i <= assign_count) begin
          rd_data = {16'h0, cosod_pkg::IDX_TX_MAP_FIRST + {8'h00, req_sub_i - 8'h01}};
        end else begin
          rd_code = cosod_pkg::RSP_NO_OBJECT;
        end
      end
      default: begin
        if (req_index_i >= cosod_pkg::IDX_TX_MAP_FIRST &&
            req_index_i <= cosod_pkg::IDX_TX_MAP_LAST) begin
          // All mapping records read alike.
          if (req_sub_i == 8'h00) begin
            rd_data = {24'h0, cosod_pkg::TX_MAP_ENTRIES};
          end else if (req_sub_i == 8'h01) begin
            rd_data = {cosod_pkg::TX_MAP1_INDEX, cosod_pkg::TX_MAP1_SUB,
                       cosod_pkg::TX_MAP1_LEN};
          end else if (req_sub_i <= cosod_pkg::TX_MAP_ENTRIES) begin
            rd_data = {cosod_pkg::TX_MAP1_INDEX + 16'(req_sub_i - 8'h01),
                       cosod_pkg::TX_MAP1_SUB, cosod_pkg::TX_MAP1_LEN};
          end else begin
            rd_code = cosod_pkg::RSP_NO_OBJECT;
          end
        end else begin
          rd_code = cosod_pkg::RSP_NO_OBJECT;
        end
      end
    endcase
    if (req_write_i && rd_code == cosod_pkg::RSP_OK && !wr_allowed) begin
      // Assignment edits outside pre-operational report a state error.
      if (req_index_i == cosod_pkg::IDX_TX_ASSIGN && !preop_i) rd_code = cosod_pkg::RSP_BAD_STATE;
      else rd_code = cosod_pkg::RSP_READ_ONLY;
    end
  end

  // Only a zero written to history subindex 0 changes stored state.
  assign hist_clear = req_valid_i && req_write_i && wr_allowed &&
                      rd_code == cosod_pkg::RSP_OK && req_wdata_i == 32'h0000_0000;

  // ****************************************
  // Response
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_abort_o <= 1'b0;
      rsp_code_o  <= cosod_pkg::RSP_OK;
      rsp_rdata_o <= 32'h0000_0000;
    end else begin
      rsp_valid_o <= req_valid_i;
      rsp_abort_o <= req_valid_i && rd_code != cosod_pkg::RSP_OK;
      rsp_code_o  <= req_valid_i ? rd_code : cosod_pkg::RSP_OK;
      rsp_rdata_o <= (req_valid_i && !req_write_i && rd_code == cosod_pkg::RSP_OK) ?
                     rd_data : 32'h0000_0000;
    end
  end

endmodule

// >>> verif/cosod_checker.sv
// Assertions on the ports of the object directory.
`timescale 1ns/1ps
module cosod_checker (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        req_valid_i,
  input wire logic        req_write_i,
  input wire logic [15:0] req_index_i,
  input wire logic [7:0]  req_sub_i,
  input wire logic        preop_i,
  input wire logic        err_active_i,
  input wire logic        err_manuf_i,
  input wire logic        rsp_valid_o,
  input wire logic        rsp_abort_o,
  input wire logic [1:0]  rsp_code_o,
  input wire logic [31:0] rsp_rdata_o,
  input wire logic [7:0]  error_summary_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_wr(idx, sub, pre);
    req_valid_i && req_write_i && req_index_i == idx && req_sub_i == sub && preop_i == pre;
  endsequence
  sequence s_abort(code);
    rsp_valid_o && rsp_abort_o && rsp_code_o == code && rsp_rdata_o == 32'h0;
  endsequence
  a_answer_next: assert property (req_valid_i |=> rsp_valid_o)
    else $error("Request got no answer.");
  a_summary_reset: assert property (disable iff (1'b0) sys_rst_i |=> !error_summary_o)
    else $error("Summary not cleared by reset.");
  a_maker_flag: assert property (!$past(sys_rst_i) |-> error_summary_o[7:1] ==
    {$past(err_manuf_i), 6'h00}) else $error("Maker or reserved bits wrong.");
  a_general_flag: assert property (!$past(sys_rst_i) |-> error_summary_o[0] ==
    ($past(err_active_i) | $past(err_manuf_i))) else $error("General bit wrong.");
  a_state_refuse: assert property (s_wr(16'h1C13, 8'h01, 1'b0) |=> s_abort(2'h3))
    else $error("Assignment write outside pre-operational not refused.");
  a_ro_refuse: assert property (s_wr(16'h1000, 8'h00, 1'b1) |=> s_abort(2'h2))
    else $error("Read-only write not refused.");
  a_missing_object: assert property (req_valid_i && req_index_i == 16'h2000 |=> s_abort(2'h1))
    else $error("Missing object not refused.");
  a_sync_code: assert property (req_valid_i && !req_write_i && req_index_i == 16'h1C00 &&
    req_sub_i inside {[8'h01:8'h04]} |=> rsp_rdata_o == {24'h000000, $past(req_sub_i)})
    else $error("Sync type code wrong.");
endmodule
bind cosod_directory cosod_checker u_chk (.clk_i, .sys_rst_i, .req_valid_i, .req_write_i,
  .req_index_i, .req_sub_i, .preop_i, .err_active_i, .err_manuf_i, .rsp_valid_o,
  .rsp_abort_o, .rsp_code_o, .rsp_rdata_o, .error_summary_o);

// >>> verif/cosod_master.sv
// Fieldbus master model that issues SDO read and write requests.
`timescale 1ns/1ps
module cosod_master (
  input  wire logic        clk_i,
  output logic             req_valid_o,
  output logic             req_write_o,
  output logic [15:0]      req_index_o,
  output logic [7:0]       req_sub_o,
  output logic [31:0]      req_wdata_o,
  input  wire logic        rsp_valid_i,
  input  wire logic        rsp_abort_i,
  input  wire logic [1:0]  rsp_code_i,
  input  wire logic [31:0] rsp_rdata_i
);
  initial {req_valid_o, req_write_o, req_index_o, req_sub_o, req_wdata_o} = 58'h0;
  // One request by index and subindex; idle lines then show the inverse pattern.
  task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] s,
                      input logic [31:0] d, output logic [35:0] r);
    @(negedge clk_i);
    {req_valid_o, req_write_o, req_index_o, req_sub_o, req_wdata_o} = {1'b1, w, i, s, d};
    @(negedge clk_i);
    r = {rsp_valid_i, rsp_abort_i, rsp_code_i, rsp_rdata_i};
    {req_valid_o, req_write_o, req_index_o, req_sub_o, req_wdata_o} = {1'b0, ~w, ~i, ~s, ~d};
  endtask
endmodule

// >>> verif/cosod_directory_tb_top.sv
// Self-checking bench for the standard object directory.
`timescale 1ns/1ps
module cosod_directory_tb_top;
  localparam logic [31:0] DTYPE = 32'h0000_0011; // Arbitrary value.
  localparam logic [31:0] PCODE = 32'h0000_2468; // Arbitrary value.
  localparam logic [31:0] SNUM  = 32'h0000_1357; // Arbitrary value.
  localparam logic [63:0] NAME  = 64'h4142_4344_4546_4748;
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, preop_i = 1'b1, err_event_i = 1'b0;
  logic        err_active_i = 1'b0, err_manuf_i = 1'b0;
  logic [4:0]  oversample_i = 5'h00;
  logic [31:0] err_code_i = 32'h0, seed = 32'h05D6AD25, v;
  logic        req_valid_i, req_write_i, rsp_valid_o, rsp_abort_o;
  logic [15:0] req_index_i;
  logic [7:0]  req_sub_i, error_summary_o;
  logic [31:0] req_wdata_i, rsp_rdata_o;
  logic [1:0]  rsp_code_o;
  int          num_errors = 0, compares = 0, cyc = 0;
  always #5 clk_i = ~clk_i;
  cosod_directory #(.DEVICE_TYPE(DTYPE), .PRODUCT_CODE(PCODE), .SERIAL_CODE(SNUM),
    .NAME_STR(NAME)) uut (.clk_i, .sys_rst_i, .req_valid_i, .req_write_i, .req_index_i,
    .req_sub_i, .req_wdata_i, .preop_i, .oversample_i, .err_event_i, .err_code_i,
    .err_active_i, .err_manuf_i, .rsp_valid_o, .rsp_abort_o, .rsp_code_o, .rsp_rdata_o,
    .error_summary_o);
  cosod_master u_master (.clk_i, .req_valid_o(req_valid_i), .req_write_o(req_write_i),
    .req_index_o(req_index_i), .req_sub_o(req_sub_i), .req_wdata_o(req_wdata_i),
    .rsp_valid_i(rsp_valid_o), .rsp_abort_i(rsp_abort_o), .rsp_code_i(rsp_code_o),
    .rsp_rdata_i(rsp_rdata_o));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [35:0] ok(input logic [31:0] d);
    return {2'h2, 2'h0, d};
  endfunction
  function automatic logic [35:0] ab(input logic [1:0] c);
    return {2'h3, c, 32'h0};
  endfunction
  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input string nm, input logic w, input logic [15:0] i,
                     input logic [7:0] s, input logic [31:0] d, input logic [35:0] exp);
    logic [35:0] r;
    u_master.xfer(w, i, s, d, r);
    chk(nm, r, exp);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    chk("summary", 36'(error_summary_o), 36'h0);
    acc("err reg", 1'h0, 16'h1001, 8'h00, rnd(), ok(32'h0));
    acc("dev type", 1'h0, 16'h1000, 8'h00, rnd(), ok(DTYPE));
    acc("type wr", 1'h1, 16'h1000, 8'h00, rnd(), ab(2'h2));
    acc("bad idx", 1'h0, 16'h2000, 8'h00, rnd(), ab(2'h1));
    acc("id num", 1'h0, 16'h1018, 8'h00, rnd(), ok(32'h4));
    acc("product", 1'h0, 16'h1018, 8'h02, rnd(), ok(PCODE));
    acc("serial", 1'h0, 16'h1018, 8'h04, rnd(), ok(SNUM));
    acc("id wr", 1'h1, 16'h1018, 8'h01, rnd(), ab(2'h2));
    acc("id sub5", 1'h0, 16'h1018, 8'h05, rnd(), ab(2'h1));
    for (int k = 0; k < 8; k++) acc("name", 1'h0, 16'h1008, 8'(k), 32'h0, ok(32'(NAME[63-8*k -: 8])));
    acc("hw wr", 1'h1, 16'h1009, 8'h00, rnd(), ab(2'h2));
    $display("identity test done");
    for (int i = 0; i < 25; i++) begin
      acc("map num", 1'h0, 16'h1A00 + 16'(i), 8'h00, rnd(), ok(32'h2B));
      acc("map one", 1'h0, 16'h1A00 + 16'(i), 8'h01, rnd(), ok(32'h6065_0120));
    end
    acc("map two", 1'h0, 16'h1A05, 8'h02, rnd(), ok(32'h6066_0120));
    acc("map end", 1'h0, 16'h1A00, 8'h2C, rnd(), ab(2'h1));
    for (int k = 0; k < 5; k++) acc("sync", 1'h0, 16'h1C00, 8'(k), 32'h0, ok(k ? 32'(k) : 32'h4));
    $display("mapping test done");
    for (int j = 0; j < 2; j++) begin
      v = j ? 32'h18 : rnd() % 32'h19;
      oversample_i = v[4:0];
      acc("asg num", 1'h0, 16'h1C13, 8'h00, rnd(), ok(v + 32'h1));
      acc("asg 1", 1'h0, 16'h1C13, 8'h01, rnd(), ok(32'h1A00));
      acc("asg last", 1'h0, 16'h1C13, 8'(v + 1), rnd(), ok(32'h1A00 + v));
    end
    preop_i = 1'b0;
    acc("asg state", 1'h1, 16'h1C13, 8'h01, rnd(), ab(2'h3));
    preop_i = 1'b1;
    acc("asg ro", 1'h1, 16'h1C13, 8'h01, rnd(), ab(2'h2));
    $display("assignment test done");
    v = rnd();
    {err_code_i, err_event_i, err_active_i, err_manuf_i} = {v, 3'h7};
    @(negedge clk_i);
    err_event_i = 1'b0;
    chk("flags", 36'(error_summary_o), 36'h81);
    acc("last err", 1'h0, 16'h1003, 8'h01, rnd(), ok(v));
    acc("err num", 1'h0, 16'h1003, 8'h00, rnd(), ok(32'h1));
    acc("err wr", 1'h1, 16'h1003, 8'h01, rnd(), ab(2'h2));
    acc("err kept", 1'h0, 16'h1003, 8'h01, rnd(), ok(v));
    acc("clear", 1'h1, 16'h1003, 8'h00, 32'h0, ok(32'h0));
    acc("cleared", 1'h0, 16'h1003, 8'h00, rnd(), ok(32'h0));
    v = rnd();
    err_code_i = v;
    fork
      acc("clr race", 1'h1, 16'h1003, 8'h00, 32'h0, ok(32'h0));
      begin
        @(negedge clk_i);
        err_event_i = 1'b1;
        @(negedge clk_i);
        err_event_i = 1'b0;
      end
    join
    acc("race num", 1'h0, 16'h1003, 8'h00, rnd(), ok(32'h1));
    acc("race err", 1'h0, 16'h1003, 8'h01, rnd(), ok(v));
    $display("error test done");
    report_and_stop();
  end
endmodule
